// ---- include/sdsp_pkg.sv ----
// Package for the single-wire debug serial port: frame layout, bit timing, memory carriers.
// Assumes a 10 MHz core clock and a serial clock chosen outside by the select bit.
package sdsp_pkg;
  localparam int CLK_MHZ = 10;
  localparam int OPC_W = 8;
  localparam int ADR_W = 16;
  localparam int DAT_W = 16;
  localparam logic [4:0] BIT_TICKS = 5'h10;
  localparam logic [4:0] SAMPLE_TICK = 5'h0A;
  localparam logic [4:0] GLITCH_TICK = 5'h08;
  localparam logic [4:0] ONE_PULSE_TICK = 5'h07;
  localparam logic [4:0] ZERO_PULSE_TICK = 5'h0D;
  localparam logic [9:0] TIMEOUT_TICKS = 10'h200;
  localparam logic [7:0] STEAL_WAIT = 8'h80;
  localparam logic [5:0] BITS_OPC = 6'h08;
  localparam logic [5:0] BITS_ADR = 6'h10;
  localparam logic [5:0] BITS_DAT = 6'h10;
  // Opcode fields used to size the frame and pick the access kind
  localparam int OPC_HW_BIT = 7;
  localparam int OPC_RD_BIT = 5;
  localparam int OPC_WORD_BIT = 3;
  localparam int OPC_BD_BIT = 2;
  localparam logic [7:0] HW_ADDR_MASK = 8'hC0;
  localparam logic [7:0] FW_DAT_MASK = 8'h60;
  typedef enum logic [3:0] {
    SDSP_IDLE = 4'b0001,
    SDSP_RX = 4'b0010,
    SDSP_BUSY = 4'b0100,
    SDSP_TX = 4'b1000
  } sdsp_state_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic bd;
    logic [ADR_W-1:0] addr;
    logic [DAT_W-1:0] wdata;
  } sdsp_mreq_t;
  typedef struct packed {
    logic gnt;
    logic [DAT_W-1:0] rdata;
  } sdsp_mrsp_t;
  typedef struct packed {
    logic valid;
    logic [OPC_W-1:0] opcode;
    logic [DAT_W-1:0] data;
  } sdsp_fw_t;
endpackage : sdsp_pkg

// ---- rtl/sdsp_port.sv ----
// Single-wire debug serial port: bit engine, frame collector, hardware memory access.
// Assumes pin_in synchronous to clk; tgt_tick marks serial clock edges chosen by the select bit.
//
// How it works
// - Frame is 8-bit opcode then optional 16-bit address and/or 16-bit data.
// - Every read returns a full 16-bit word.
// - Byte read: even address data in upper byte, odd address in lower.
// - Word access ignores address bit zero.
// - Hardware access waits up to 128 cycles for free bus, then steals.
// - Serial timing uses target clock chosen by serial clock select bit.
// - Bits last 16 target cycles, sent MSB first.
// - Interface times out after 512 target cycles between falling edges.
// - Transmitter drives the speedup pulse ending a low level.
// - Device samples host bit ten target cycles after perceived edge.
// - Device sending one drives speedup pulse seven cycles after bit start.
// - Device sending zero holds low 13 cycles then speedup pulse.
// - Pin is mode select during reset, serial line afterwards.
`timescale 1ns/1ps
`default_nettype none
module sdsp_port
  import sdsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tgt_tick,
  input wire logic serial_clock_select,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic mode_special,
  output sdsp_pkg::sdsp_mreq_t mreq,
  input wire sdsp_pkg::sdsp_mrsp_t mrsp,
  input wire logic bus_free,
  output sdsp_pkg::sdsp_fw_t fw_cmd,
  input wire logic fw_rd_valid,
  input wire logic [15:0] fw_rd_data,
  output logic serial_timeout
);
  import sdsp_pkg::*;

  sdsp_state_t st_q, st_d;
  logic pin_q, pin_d;
  logic [4:0] tick_q, tick_d;
  logic [9:0] idle_q, idle_d;
  logic in_bit_q, in_bit_d;
  logic [5:0] cnt_q, cnt_d;
  logic [5:0] need_q, need_d;
  logic [OPC_W-1:0] opc_q, opc_d;
  logic [DAT_W-1:0] sh_q, sh_d;
  logic [ADR_W-1:0] adr_q, adr_d;
  logic [1:0] phase_q, phase_d;
  logic [7:0] wait_q, wait_d;
  logic mode_q, mode_d;
  logic started_q, started_d;
  logic tx_bit_q, tx_bit_d;
  logic pout_q, pout_d;
  logic poe_q, poe_d;
  logic tmo_q, tmo_d;
  sdsp_mreq_t mreq_q, mreq_d;
  sdsp_fw_t fw_q, fw_d;

  logic fall;
  logic is_hw, is_rd, is_word;
  logic [DAT_W-1:0] rd_word;
  logic [OPC_W-1:0] opc_in;

  // Falling edge seen one clock late at most; counts from the perceived edge
  assign fall = pin_q & ~pin_in & ~poe_q;
  assign is_hw = opc_q[OPC_HW_BIT];
  assign is_rd = opc_q[OPC_RD_BIT];
  assign is_word = opc_q[OPC_WORD_BIT];
  assign opc_in = {sh_q[OPC_W-2:0], pin_in};

  // Byte read placement; word reads come back whole
  always_comb begin
    if (is_word) begin
      rd_word = mrsp.rdata;
    end else if (adr_q[0]) begin
      rd_word = {8'h00, mrsp.rdata[7:0]};
    end else begin
      rd_word = {mrsp.rdata[15:8], 8'h00};
    end
  end

  always_comb begin
    st_d = st_q;
    pin_d = pin_in;
    tick_d = tick_q;
    idle_d = idle_q;
    in_bit_d = in_bit_q;
    cnt_d = cnt_q;
    need_d = need_q;
    opc_d = opc_q;
    sh_d = sh_q;
    adr_d = adr_q;
    phase_d = phase_q;
    wait_d = wait_q;
    mode_d = mode_q;
    started_d = 1'b1;
    tx_bit_d = tx_bit_q;
    pout_d = 1'b0;
    poe_d = 1'b0;
    tmo_d = 1'b0;
    mreq_d = mreq_q;
    fw_d = fw_q;
    fw_d.valid = 1'b0;
    // Strap caught on the first clock after reset release
    if (!started_q) begin
      mode_d = ~pin_in;
    end
    // Bit timer runs on target clock ticks only
    if (in_bit_q && tgt_tick) begin
      tick_d = tick_q + 5'h01;
      if (tick_q == BIT_TICKS - 5'h01) begin
        in_bit_d = 1'b0;
      end
    end
    if (tgt_tick && st_q != SDSP_IDLE && st_q != SDSP_BUSY) begin
      if (idle_q == TIMEOUT_TICKS - 10'h001) begin
        // Partial frame is dropped; next edge begins a fresh opcode
        st_d = SDSP_IDLE;
        cnt_d = 6'h00;
        tmo_d = 1'b1;
        idle_d = 10'h000;
      end else begin
        idle_d = idle_q + 10'h001;
      end
    end
    if (fall && started_q && st_q != SDSP_BUSY) begin
      tick_d = 5'h00;
      in_bit_d = 1'b1;
      idle_d = 10'h000;
      if (st_q == SDSP_IDLE) begin
        st_d = SDSP_RX;
        cnt_d = 6'h00;
        need_d = BITS_OPC;
        phase_d = 2'd0;
      end
      if (st_q == SDSP_TX) begin
        tx_bit_d = sh_q[DAT_W-1];
        sh_d = {sh_q[DAT_W-2:0], 1'b0};
      end
    end
    case (st_q)
      SDSP_RX: begin
        if (in_bit_q && tgt_tick && tick_q == SAMPLE_TICK - 5'h01) begin
          // Sampled at tick ten; a slow host one is a zero here
          sh_d = {sh_q[DAT_W-2:0], pin_in};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q + 6'h01 == need_q) begin
            cnt_d = 6'h00;
            if (phase_q == 2'd0) begin
              opc_d = {sh_q[OPC_W-2:0], pin_in};
              if (opc_in[OPC_HW_BIT]) begin
                need_d = BITS_ADR;
                phase_d = 2'd1;
              end else if (({sh_q[6:0], pin_in} & FW_DAT_MASK) == 8'h40) begin
                need_d = BITS_DAT;
                phase_d = 2'd2;
              end else begin
                fw_d.valid = 1'b1;
                fw_d.opcode = {sh_q[OPC_W-2:0], pin_in};
                // Firmware reads park in busy until the data arrives
                st_d = ({sh_q[6:0], pin_in} & FW_DAT_MASK) == FW_DAT_MASK ?
                  SDSP_BUSY : SDSP_IDLE;
              end
            end else if (phase_q == 2'd1) begin
              adr_d = {sh_q[DAT_W-2:0], pin_in};
              if (!is_rd) begin
                need_d = BITS_DAT;
                phase_d = 2'd2;
              end else begin
                st_d = SDSP_BUSY;
                wait_d = 8'h00;
                mreq_d.req = 1'b1;
                mreq_d.wr = 1'b0;
                mreq_d.bd = opc_q[OPC_BD_BIT];
                mreq_d.addr = is_word ? {sh_q[DAT_W-2:0], 1'b0} :
                  {sh_q[DAT_W-2:0], pin_in};
              end
            end else begin
              if (is_hw) begin
                st_d = SDSP_BUSY;
                wait_d = 8'h00;
                mreq_d.req = 1'b1;
                mreq_d.wr = 1'b1;
                mreq_d.bd = opc_q[OPC_BD_BIT];
                mreq_d.addr = is_word ? {adr_q[ADR_W-1:1], 1'b0} : adr_q;
                mreq_d.wdata = {sh_q[DAT_W-2:0], pin_in};
              end else begin
                st_d = SDSP_IDLE;
                fw_d.valid = 1'b1;
                fw_d.opcode = opc_q;
                fw_d.data = {sh_q[DAT_W-2:0], pin_in};
              end
            end
          end
        end
      end
      SDSP_BUSY: begin
        if (!is_hw) begin
          if (fw_rd_valid) begin
            sh_d = fw_rd_data;
            in_bit_d = 1'b0;
            st_d = SDSP_TX;
            cnt_d = 6'h00;
            idle_d = 10'h000;
          end
        end else if (mreq_q.req) begin
          // Free cycle preferred; after the wait a cycle is stolen anyway
          if (wait_q != STEAL_WAIT) begin
            wait_d = wait_q + 8'h01;
          end
          if (mrsp.gnt && (bus_free || wait_q == STEAL_WAIT)) begin
            mreq_d.req = 1'b0;
            if (mreq_q.wr) begin
              st_d = SDSP_IDLE;
            end else begin
              sh_d = rd_word;
              // Timer of the last request bit may still run; it must not drive the pin
              in_bit_d = 1'b0;
              st_d = SDSP_TX;
              cnt_d = 6'h00;
              idle_d = 10'h000;
            end
          end
        end
      end
      SDSP_TX: begin
        if (in_bit_q) begin
          if (!tx_bit_q && tick_q < ZERO_PULSE_TICK) begin
            poe_d = 1'b1;
          end else if (tick_q == (tx_bit_q ? ONE_PULSE_TICK : ZERO_PULSE_TICK)) begin
            poe_d = 1'b1;
            pout_d = 1'b1;
          end
          if (tgt_tick && tick_q == BIT_TICKS - 5'h01) begin
            cnt_d = cnt_q + 6'h01;
            if (cnt_q + 6'h01 == BITS_DAT) begin
              st_d = SDSP_IDLE;
            end
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= SDSP_IDLE;
      pin_q <= 1'b1;
      tick_q <= 5'h00;
      idle_q <= 10'h000;
      in_bit_q <= 1'b0;
      cnt_q <= 6'h00;
      need_q <= 6'h00;
      opc_q <= 8'h00;
      sh_q <= 16'h0000;
      adr_q <= 16'h0000;
      phase_q <= 2'd0;
      wait_q <= 8'h00;
      mode_q <= 1'b0;
      started_q <= 1'b0;
      tx_bit_q <= 1'b0;
      pout_q <= 1'b0;
      poe_q <= 1'b0;
      tmo_q <= 1'b0;
      mreq_q <= '0;
      fw_q <= '0;
    end else begin
      st_q <= st_d;
      pin_q <= pin_d;
      tick_q <= tick_d;
      idle_q <= idle_d;
      in_bit_q <= in_bit_d;
      cnt_q <= cnt_d;
      need_q <= need_d;
      opc_q <= opc_d;
      sh_q <= sh_d;
      adr_q <= adr_d;
      phase_q <= phase_d;
      wait_q <= wait_d;
      mode_q <= mode_d;
      started_q <= started_d;
      tx_bit_q <= tx_bit_d;
      pout_q <= pout_d;
      poe_q <= poe_d;
      tmo_q <= tmo_d;
      mreq_q <= mreq_d;
      fw_q <= fw_d;
    end
  end

  // Pin is never driven while reset holds, so the strap reads cleanly
  assign pin_out = pout_q;
  assign pin_oe = poe_q;
  assign mode_special = mode_q;
  assign mreq = mreq_q;
  assign fw_cmd = fw_q;
  assign serial_timeout = tmo_q;
  // Select bit only chooses the tick source outside this block
  logic unused_sel;
  assign unused_sel = serial_clock_select;
endmodule : sdsp_port
`default_nettype wire

// ---- testbench/sdsp_port_assertions.sv ----
// Checker for sdsp_port: pin drive timing, timeout, bus request and strap rules.
// Sees only the port pins; pacing comes from tgt_tick.
`timescale 1ns/1ps
`default_nettype none
module sdsp_port_assertions
  import sdsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tgt_tick,
  input wire logic pin_in,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic mode_special,
  input wire sdsp_pkg::sdsp_mreq_t mreq,
  input wire logic bus_free,
  input wire sdsp_pkg::sdsp_fw_t fw_cmd,
  input wire logic serial_timeout
);
  logic in_q;
  logic [10:0] since_q;
  logic [7:0] wait_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Ticks since the last host edge; saturates so long idles stay large
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_q <= 1'b1;
      since_q <= 11'h7ff;
      wait_q <= 8'h00;
    end else begin
      in_q <= pin_in;
      wait_q <= mreq.req ? wait_q + {7'h00, wait_q != 8'hff} : 8'h00;
      if (in_q && !pin_in && !pin_oe) since_q <= 11'h000;
      else if (tgt_tick && since_q != 11'h7ff) since_q <= since_q + 11'h001;
    end
  end
  property p_strap; $past(rst) |=> mode_special == !$past(pin_in); endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");
  property p_one; $rose(pin_oe) && pin_out |-> since_q inside {[11'd6:11'd8]}; endproperty
  a_one: assert property (p_one) else $error("one pulse mistimed");
  property p_zero; $past(pin_oe && !pin_out) && pin_oe && pin_out |-> since_q inside {[11'd12:11'd14]}; endproperty
  a_zero: assert property (p_zero) else $error("zero low length wrong");
  property p_brief; $rose(pin_oe && pin_out) |-> ##[1:4] !(pin_oe && pin_out); endproperty
  a_brief: assert property (p_brief) else $error("speedup pulse too long");
  property p_timeout; serial_timeout |-> since_q >= 11'd510; endproperty
  a_timeout: assert property (p_timeout) else $error("early timeout");
  property p_no_early; mreq.req && !bus_free && wait_q < 8'd120 |=> mreq.req; endproperty
  a_no_early: assert property (p_no_early) else $error("bus stolen early");
  property p_steal; $rose(mreq.req) |-> ##[1:140] !mreq.req; endproperty
  a_steal: assert property (p_steal) else $error("access never completed");
  property p_after; $rose(mreq.req) || $rose(fw_cmd.valid) |-> since_q >= 11'd10; endproperty
  a_after: assert property (p_after) else $error("request before last sample");
  c_timeout: cover property (serial_timeout);
  c_steal: cover property (mreq.req && !bus_free && wait_q == 8'd127);
  c_one: cover property ($rose(pin_oe) && pin_out);
endmodule : sdsp_port_assertions
`default_nettype wire

// ---- testbench/sdsp_host_model.sv ----
// Debug host model: opens every bit with a low and paces it in target ticks.
// Drives only low; release and the pull-up give the high level.
`timescale 1ns/1ps
`default_nettype none
module sdsp_host_model (
  input wire logic clk,
  input wire logic tgt_tick,
  input wire logic pin_lvl,
  output var logic host_low
);
  initial host_low = 1'b0;
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff tgt_tick);
    @(negedge clk);
  endtask : ticks
  task automatic bit1(input logic b);
    host_low = 1'b1;
    ticks(b ? 4 : 13);
    host_low = 1'b0;
    ticks(b ? 14 : 5);
  endtask : bit1
  task automatic send_op(input logic [7:0] op);
    for (int i = 7; i >= 0; i--) bit1(op[i]);
  endtask : send_op
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) bit1(w[i]);
  endtask : send
  task automatic recv(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      host_low = 1'b1;
      ticks(3);
      host_low = 1'b0;
      ticks(7);
      w[i] = pin_lvl;
      ticks(8);
    end
  endtask : recv
endmodule : sdsp_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Bench for sdsp_port: host model on the pin, memory and firmware responders.
// Ticks every second clock; the memory grant follows the request.
`timescale 1ns/1ps
`default_nettype none
bind sdsp_port sdsp_port_assertions u_chk (.clk(clk), .rst(rst), .tgt_tick(tgt_tick),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mode_special(mode_special),
  .mreq(mreq), .bus_free(bus_free), .fw_cmd(fw_cmd), .serial_timeout(serial_timeout));
module tb;
  import sdsp_pkg::*;
  logic clk, rst, pin_out, pin_oe, mode_special, bus_free, fw_rd_valid;
  logic tgt_tick = 1'b0;
  logic serial_timeout, host_low, pin_in;
  logic [15:0] fw_rd_data, mem_q, got;
  sdsp_mreq_t mreq;
  sdsp_mrsp_t mrsp = '0;
  sdsp_fw_t fw_cmd;
  sdsp_mreq_t req_cap;
  sdsp_fw_t fw_cap;
  int n_req = 0, n_fw = 0;
  int n_errors = 0, checks_done = 0, cyc = 0;
  assign pin_in = (pin_oe ? pin_out : 1'b1) & ~host_low; // Pull-up; a low drive wins
  sdsp_port dut (.clk(clk), .rst(rst), .tgt_tick(tgt_tick), .serial_clock_select(1'b1),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mode_special(mode_special),
    .mreq(mreq), .mrsp(mrsp), .bus_free(bus_free), .fw_cmd(fw_cmd),
    .fw_rd_valid(fw_rd_valid), .fw_rd_data(fw_rd_data), .serial_timeout(serial_timeout));
  sdsp_host_model host (.clk(clk), .tgt_tick(tgt_tick), .pin_lvl(pin_in), .host_low(host_low));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  always @(negedge clk) begin
    tgt_tick <= ~tgt_tick;
    mrsp <= {mreq.req, mem_q};
    cyc <= cyc + 1;
    // A granted request or a firmware pulse may last one clock; keep the latest
    if (mreq.req === 1'b1) begin
      req_cap <= mreq;
      n_req <= n_req + 1;
    end
    if (fw_cmd.valid === 1'b1) begin
      fw_cap <= fw_cmd;
      n_fw <= n_fw + 1;
    end
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // Byte accesses carry one valid lane, chosen by address bit zero
  function automatic logic [15:0] lane(input logic [7:0] op, input logic [15:0] a);
    return op[3] ? 16'hffff : (a[0] ? 16'h00ff : 16'hff00);
  endfunction : lane
  task automatic hw(input logic [7:0] op, input logic [15:0] a, d);
    int seen;
    mem_q = 16'($urandom);
    seen = n_req;
    host.send_op(op);
    host.send(a);
    if (!op[5]) host.send(d);
    for (int k = 0; k < 300 && n_req == seen; k++) @(negedge clk);
    chk(req_cap.addr, op[3] ? {a[15:1], 1'b0} : a, "addr");
    chk(16'({req_cap.req, req_cap.wr, req_cap.bd}), 16'({1'b1, ~op[5], op[2]}), "kind");
    if (!op[5]) chk(req_cap.wdata & lane(op, a), d & lane(op, a), "wdata");
    repeat (200) @(negedge clk);
    if (op[5]) host.recv(got);
    if (op[5]) chk(got & lane(op, a), mem_q & lane(op, a), "rdata");
  endtask : hw
  task automatic fw(input logic [7:0] op, input logic [15:0] d);
    int seen;
    seen = n_fw;
    host.send_op(op);
    if (op[7:5] == 3'b010) host.send(d);
    for (int k = 0; k < 300 && n_fw == seen; k++) @(negedge clk);
    chk(16'({fw_cap.valid, fw_cap.opcode}), 16'({1'b1, op}), "fw op");
    if (op[7:5] == 3'b010) chk(fw_cap.data, d, "fw data");
    fw_rd_data = 16'($urandom);
    fw_rd_valid = op[7:5] == 3'b011;
    @(negedge clk);
    fw_rd_valid = 1'b0;
    repeat (80) @(negedge clk);
    if (op[7:5] == 3'b011) host.recv(got);
    if (op[7:5] == 3'b011) chk(got, fw_rd_data, "fw rdata");
  endtask : fw
  initial begin
    rst = 1'b1;
    bus_free = 1'b1;
    fw_rd_valid = 1'b0;
    fw_rd_data = 16'h0000;
    mem_q = 16'h0000;
    void'($urandom(32'he792));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(mode_special), 16'h0000, "mode");
    // Every hardware code; even passes make the port steal the bus
    for (int i = 0; i < 8; i++) begin
      bus_free = i[0];
      hw(8'hc0 | {2'b00, i[2], 1'b0, i[1], i[0], 2'b00}, {15'($urandom), i[0]}, 16'($urandom));
    end
    fw(8'h44, 16'($urandom));
    fw(8'h64, 16'h0000);
    fw(8'h10, 16'h0000);
    host.bit1(1'b1);
    host.bit1(1'b0);
    for (int k = 0; k < 1400 && serial_timeout !== 1'b1; k++) @(negedge clk);
    chk(16'(serial_timeout), 16'h0001, "timeout");
    hw(8'he8, 16'hfffe, 16'h0000);
    rst = 1'b1;
    host.host_low = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(mode_special), 16'h0001, "strap");
    host.host_low = 1'b0;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
